//--- sim/serial_shift_clock_select_bench.sv
// Testbench: registers, clock sources, strobes, interrupt and pin routing
`timescale 1ns/1ps
module serial_shift_clock_select_bench;
    logic        clk_sys;
    logic        arst_n;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq;
    logic        timerMatch;
    logic        useA;
    logic        mClkA, mDatA, mClkB, mDatB;
    logic        diB, diBOut, diBOeN, doBOut, doBOeN, ckB, ckBOut, ckBOeN;
    logic        diA, diAOut, diAOeN, doAOut, doAOeN, ckA, ckAOut, ckAOeN;
    int          errTotal;
    int          samplesChecked;
    // Wire level: design drives when its enable is low, else the partner
    assign diB = diBOeN ? mDatB : diBOut;
    assign ckB = ckBOeN ? mClkB : ckBOut;
    assign diA = diAOeN ? mDatA : diAOut;
    assign ckA = ckAOeN ? mClkA : ckAOut;

    sscs_core uut (.clk_sys(clk_sys), .arst_n(arst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq), .timerMatch(timerMatch), .dataInPinB(diB),
        .dataInPinBOut(diBOut), .dataInPinBOeN(diBOeN), .dataOutPinBOut(doBOut),
        .dataOutPinBOeN(doBOeN), .clockPinB(ckB), .clockPinBOut(ckBOut),
        .clockPinBOeN(ckBOeN), .dataInPinA(diA), .dataInPinAOut(diAOut),
        .dataInPinAOeN(diAOeN), .dataOutPinAOut(doAOut), .dataOutPinAOeN(doAOeN),
        .clockPinA(ckA), .clockPinAOut(ckAOut), .clockPinAOeN(ckAOeN));
    sscs_partner far (.clk_sys(clk_sys), .useA(useA), .clkA(mClkA), .datA(mDatA),
        .clkB(mClkB), .datB(mDatB));

    initial
    begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic giveVerdict();
        $display("Comparisons %0d, mismatches %0d", samplesChecked, errTotal);
        if (errTotal == 0 && samplesChecked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samplesChecked++;
        if (got !== exp)
        begin
            errTotal++;
            $display("FAIL at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chkBit(input logic got, input logic exp);
        chk({31'h0000_0000, got}, {31'h0000_0000, exp});
    endtask
    task automatic ticks(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    // Holds the request until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
                       output logic [31:0] rd, output logic er);
        int n;
        n = 0;
        @(posedge clk_sys);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= {24'h00_0000, d};
        @(posedge clk_sys);
        penable <= 1'b1;
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n >= 20 && pready !== 1'b1)
        begin
            errTotal++;
            giveVerdict();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] rd;
        logic        er;
        apb(1'b1, a, d, rd, er);
    endtask
    task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
        logic [31:0] rd;
        logic        er;
        apb(1'b0, a, 8'h00, rd, er);
        chk(rd, {24'h00_0000, exp});
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic tResetMap();
        logic [31:0] rd;
        logic        er;
        rdChk(sscs_pkg::OFF_CTRL, 8'h00);
        rdChk(sscs_pkg::OFF_PINPOS, 8'h00);
        apb(1'b0, 8'h40, 8'h00, rd, er);
        chkBit(er, 1'b1);
        wr(sscs_pkg::OFF_PINPOS, 8'hFF);
        rdChk(sscs_pkg::OFF_PINPOS, 8'h01);
        wr(sscs_pkg::OFF_PINPOS, 8'h00);
    endtask
    task automatic tStrobe();
        far.setDat(1'b1);
        wr(sscs_pkg::OFF_DIR, 8'h01);
        wr(sscs_pkg::OFF_CTRL, 8'h10);
        wr(sscs_pkg::OFF_DATA, 8'h81);
        wr(sscs_pkg::OFF_COUNT, 8'h00);
        ticks(2);
        chkBit(doBOut, 1'b1);
        wr(sscs_pkg::OFF_CTRL, 8'h12);
        ticks(1);
        chkBit(doBOut, 1'b0);
        rdChk(sscs_pkg::OFF_DATA, 8'h03);
        rdChk(sscs_pkg::OFF_COUNT, 8'h01);
        rdChk(sscs_pkg::OFF_CTRL, 8'h10);
        wr(sscs_pkg::OFF_CTRL, 8'h10);
        rdChk(sscs_pkg::OFF_DATA, 8'h03);
    endtask
    task automatic tIrq();
        wr(sscs_pkg::OFF_MASK, 8'h00);
        wr(sscs_pkg::OFF_COUNT, 8'h0F);
        wr(sscs_pkg::OFF_CTRL, 8'h02);
        rdChk(sscs_pkg::OFF_COUNT, 8'h00);
        chkBit(irq, 1'b0);
        wr(sscs_pkg::OFF_MASK, 8'h01);
        ticks(2);
        chkBit(irq, 1'b1);
        rdChk(sscs_pkg::OFF_STATUS, 8'h01);
        ticks(2);
        chkBit(irq, 1'b0);
        rdChk(sscs_pkg::OFF_STATUS, 8'h00);
        wr(sscs_pkg::OFF_MASK, 8'h00);
    endtask
    task automatic tTimer();
        wr(sscs_pkg::OFF_DATA, 8'h00);
        wr(sscs_pkg::OFF_COUNT, 8'h00);
        wr(sscs_pkg::OFF_CTRL, 8'h04);
        repeat (3)
        begin
            timerMatch <= 1'b1;
            ticks(1);
            timerMatch <= 1'b0;
            ticks(3);
        end
        rdChk(sscs_pkg::OFF_COUNT, 8'h03);
        rdChk(sscs_pkg::OFF_DATA, 8'h07);
        wr(sscs_pkg::OFF_CTRL, 8'h06);
        rdChk(sscs_pkg::OFF_COUNT, 8'h03);
    endtask
    // Outputs disabled by wire mode 00 while the pin clock still shifts and counts
    task automatic tExternal(input logic [7:0] val, input logic negEdge);
        wr(sscs_pkg::OFF_COUNT, 8'h00);
        wr(sscs_pkg::OFF_CTRL, {4'h0, 1'b1, negEdge, 2'h0});
        far.sendByte(val, negEdge);
        ticks(8);
        rdChk(sscs_pkg::OFF_DATA, val);
        rdChk(sscs_pkg::OFF_COUNT, 8'h00);
        rdChk(sscs_pkg::OFF_STATUS, 8'h01);
    endtask
    task automatic tToggle();
        wr(sscs_pkg::OFF_DIR, 8'h02);
        wr(sscs_pkg::OFF_CTRL, 8'h1A);
        wr(sscs_pkg::OFF_COUNT, 8'h00);
        wr(sscs_pkg::OFF_CTRL, 8'h1B);
        ticks(2);
        chkBit(ckBOut, 1'b1);
        chkBit(ckBOeN, 1'b0);
        wr(sscs_pkg::OFF_CTRL, 8'h1B);
        ticks(8);
        chkBit(ckBOut, 1'b0);
        rdChk(sscs_pkg::OFF_COUNT, 8'h02);
        wr(sscs_pkg::OFF_DIR, 8'h00);
        wr(sscs_pkg::OFF_CTRL, 8'h1B);
        ticks(2);
        chkBit(ckBOut, 1'b1);
        chkBit(ckBOeN, 1'b1);
        rdChk(sscs_pkg::OFF_COUNT, 8'h03);
    endtask
    task automatic tPinA();
        wr(sscs_pkg::OFF_CTRL, 8'h00);
        wr(sscs_pkg::OFF_PINPOS, 8'h01);
        useA <= 1'b1;
        tExternal(8'h5A, 1'b0);
        // Three-wire outputs land on port A only; clock port left high by the toggles
        wr(sscs_pkg::OFF_DIR, 8'h03);
        wr(sscs_pkg::OFF_DATA, 8'h80);
        wr(sscs_pkg::OFF_CTRL, 8'h10);
        ticks(1);
        chkBit(doAOut, 1'b1);
        chkBit(doAOeN, 1'b0);
        chkBit(ckAOut, 1'b1);
        chkBit(ckAOeN, 1'b0);
        chkBit(doBOeN, 1'b1);
        chkBit(ckBOeN, 1'b1);
        // Open drain: data-in pin pulled low by a zero output bit
        wr(sscs_pkg::OFF_DATA, 8'h00);
        wr(sscs_pkg::OFF_CTRL, 8'h20);
        ticks(1);
        chkBit(diAOut, 1'b0);
        chkBit(diAOeN, 1'b0);
        chkBit(ckAOeN, 1'b1);
        chkBit(doAOeN, 1'b1);
        chkBit(diBOeN, 1'b1);
        chkBit(diBOut, 1'b0);
        // Hold mode keeps the clock pin low until the overflow flag is read
        wr(sscs_pkg::OFF_COUNT, 8'h0F);
        wr(sscs_pkg::OFF_CTRL, 8'h32);
        ticks(1);
        chkBit(ckAOeN, 1'b0);
        rdChk(sscs_pkg::OFF_STATUS, 8'h01);
        ticks(1);
        chkBit(ckAOeN, 1'b1);
    endtask

    initial
    begin
        arst_n         = 1'b0;
        psel           = 1'b0;
        penable        = 1'b0;
        pwrite         = 1'b0;
        paddr          = 8'h00;
        pwdata         = 32'h0000_0000;
        timerMatch     = 1'b0;
        useA           = 1'b0;
        errTotal       = 0;
        samplesChecked = 0;
        ticks(5);
        arst_n <= 1'b1;
        ticks(6);
        tResetMap();
        tStrobe();
        tIrq();
        tTimer();
        tExternal(8'hA5, 1'b0);
        tExternal(8'h3C, 1'b1);
        tToggle();
        tPinA();
        giveVerdict();
    end
endmodule

//--- sim/sscs_partner.sv
// Partner: external serial master that clocks the data-in and clock pins
`timescale 1ns/1ps
module sscs_partner
(
    input  wire logic clk_sys,
    input  wire logic useA,
    output logic      clkA,
    output logic      datA,
    output logic      clkB,
    output logic      datB
);
    logic lnkClk;
    logic lnkDat;
    // Link clock stands still at 0 outside frames
    assign clkA = useA ? lnkClk : 1'b0;
    assign clkB = useA ? 1'b0 : lnkClk;
    // Unselected data line shows the inverse, so no stale copy can pass
    assign datA = useA ? lnkDat : ~lnkDat;
    assign datB = useA ? ~lnkDat : lnkDat;
    initial
    begin
        lnkClk = 1'b0;
        lnkDat = 1'b0;
    end
    task automatic setDat(input logic v);
        @(posedge clk_sys);
        lnkDat <= v;
    endtask
    // MSB first, 320 ns per bit; data moves half a period before the sampling edge
    task automatic sendByte(input logic [7:0] val, input logic negEdge);
        @(posedge clk_sys);
        for (int i = 7; i >= 0; i--)
        begin
            lnkDat <= val[i];
            lnkClk <= negEdge;
            repeat (4) @(posedge clk_sys);
            lnkClk <= ~negEdge;
            repeat (4) @(posedge clk_sys);
        end
        lnkClk <= 1'b0;
        lnkDat <= ~val[0];
    endtask
endmodule

//--- verilog/sscs_core.sv
// Serial shift unit: clock source select, strobes, pin routing, APB registers
`timescale 1ns/1ps
module sscs_core
(
    input  wire logic        clk_sys,
    input  wire logic        arst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             irq,
    input  wire logic        timerMatch,
    input  wire logic        dataInPinB,
    output logic             dataInPinBOut,
    output logic             dataInPinBOeN,
    output logic             dataOutPinBOut,
    output logic             dataOutPinBOeN,
    input  wire logic        clockPinB,
    output logic             clockPinBOut,
    output logic             clockPinBOeN,
    input  wire logic        dataInPinA,
    output logic             dataInPinAOut,
    output logic             dataInPinAOeN,
    output logic             dataOutPinAOut,
    output logic             dataOutPinAOeN,
    input  wire logic        clockPinA,
    output logic             clockPinAOut,
    output logic             clockPinAOeN
);

    typedef struct packed
    {
        logic [7:0]  shreg;
        logic [3:0]  cnt;
        logic [1:0]  css;
        logic [1:0]  wireMode;
        logic        clkSel;
        logic        clkPort;
        logic        loc;
        logic [1:0]  dir;
        logic        status;
        logic        mask;
        logic        doLatch;
        logic        diPrev;
        logic        clkPrev;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
        logic        irq;
        logic [5:0]  pinOut;
        logic [5:0]  pinOeN;
    } sscs_state_t;

    sscs_state_t state_q;
    sscs_state_t state_d;
    logic [3:0]  syncPins;
    logic        di;
    logic        ck;
    logic        rise;
    logic        fall;
    logic        access;
    logic        ctrlWr;
    logic        strobe;
    logic        toggle;
    logic [1:0]  cssNow;
    logic        selNow;
    logic        shift;
    logic        cntInc;
    logic        shIn;
    logic        dataWr;
    logic        cntWr;
    logic        dout;
    logic        clkHold;
    logic        readCtrl;

    function automatic logic sscs_is_ext(input logic [1:0] css);
        sscs_is_ext = css[1];
    endfunction

    // ------------------------------------------------------------------
    // Pin input synchronisers
    // ------------------------------------------------------------------
    sscs_sync uSync
    (
        .clk_sys (clk_sys),
        .arst_n  (arst_n),
        .pinIn   ({clockPinA, dataInPinA, clockPinB, dataInPinB}),
        .pinOut  (syncPins)
    );

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb
    begin
        state_d = state_q;
        // Inputs stay live in every wire mode
        di   = state_q.loc ? syncPins[2] : syncPins[0];
        ck   = state_q.loc ? syncPins[3] : syncPins[1];
        rise = ck & ~state_q.clkPrev;
        fall = ~ck & state_q.clkPrev;
        state_d.clkPrev = ck;
        state_d.diPrev  = di;

        access   = psel & penable & state_q.pready;
        ctrlWr   = access & pwrite & (paddr == sscs_pkg::OFF_CTRL);
        dataWr   = access & pwrite & (paddr == sscs_pkg::OFF_DATA);
        cntWr    = access & pwrite & (paddr == sscs_pkg::OFF_COUNT);
        strobe   = ctrlWr & pwdata[sscs_pkg::CTRL_STROBE_POS];
        toggle   = ctrlWr & pwdata[sscs_pkg::CTRL_TOGGLE_POS];
        cssNow   = ctrlWr ? pwdata[sscs_pkg::CTRL_CSS_POS +: 2] : state_q.css;
        selNow   = ctrlWr ? pwdata[sscs_pkg::CTRL_STROBE_POS] : state_q.clkSel;
        readCtrl = psel & penable & ~state_q.pready & ~pwrite
                 & (paddr == sscs_pkg::OFF_CTRL);

        if (ctrlWr)
        begin
            state_d.wireMode = pwdata[sscs_pkg::CTRL_WM_POS +: 2];
            state_d.css      = cssNow;
            state_d.clkSel   = selNow;
        end

        // Clock source selection
        shift  = 1'b0;
        cntInc = 1'b0;
        shIn   = state_q.diPrev;
        if (cssNow == sscs_pkg::CSS_NONE_SW)
        begin
            shift  = strobe;
            cntInc = strobe;
        end
        else if (cssNow == sscs_pkg::CSS_TIMER)
        begin
            shift  = timerMatch;
            cntInc = timerMatch;
        end
        else
        begin
            shIn   = di;
            shift  = cssNow[0] ? fall : rise;
            cntInc = selNow ? toggle : (rise | fall);
            if (cssNow[0] ? rise : fall)
                state_d.doLatch = state_q.shreg[7];
        end

        // Software load wins over a shift in the same cycle
        if (dataWr)
            state_d.shreg = pwdata[7:0];
        else if (shift)
            state_d.shreg = {state_q.shreg[6:0], shIn};

        if (cntWr)
            state_d.cnt = pwdata[3:0];
        else if (cntInc)
            state_d.cnt = 4'(state_q.cnt + 4'h1);

        if (toggle)
            state_d.clkPort = ~state_q.clkPort;

        // Read clears only what the read reported, so a new event is kept
        if (access & ~pwrite & (paddr == sscs_pkg::OFF_STATUS))
            state_d.status = state_q.status & ~state_q.prdata[sscs_pkg::STAT_OVF_POS];
        if (cntInc & ~cntWr & (state_q.cnt == sscs_pkg::CNT_MAX))
            state_d.status = 1'b1;

        if (access & pwrite & (paddr == sscs_pkg::OFF_PINPOS))
            state_d.loc = pwdata[sscs_pkg::PINPOS_LOC_POS];
        if (access & pwrite & (paddr == sscs_pkg::OFF_MASK))
            state_d.mask = pwdata[sscs_pkg::STAT_OVF_POS];
        if (access & pwrite & (paddr == sscs_pkg::OFF_DIR))
            state_d.dir = pwdata[1:0];

        state_d.irq = state_d.status & state_d.mask;

        // APB: one wait state, registered read data
        state_d.pready  = psel & penable & ~state_q.pready;
        state_d.pslverr = 1'b0;
        state_d.prdata  = 32'h0000_0000;
        if (psel & penable & ~state_q.pready)
        begin
            unique case (paddr)
                sscs_pkg::OFF_CTRL:
                    // Strobe bits read as zero
                    state_d.prdata[7:0] = {2'h0, state_q.wireMode, state_q.css, 2'h0};
                sscs_pkg::OFF_PINPOS:
                    state_d.prdata[0] = state_q.loc;
                sscs_pkg::OFF_DATA:   state_d.prdata[7:0] = state_q.shreg;
                sscs_pkg::OFF_STATUS: state_d.prdata[0]   = state_q.status;
                sscs_pkg::OFF_MASK:   state_d.prdata[0]   = state_q.mask;
                sscs_pkg::OFF_COUNT:  state_d.prdata[3:0] = state_q.cnt;
                sscs_pkg::OFF_DIR:    state_d.prdata[1:0] = state_q.dir;
                default:              state_d.pslverr     = 1'b1;
            endcase
        end

        // Output latch: transparent unless an external clock is used
        dout    = sscs_is_ext(state_d.css) ? state_d.doLatch : state_d.shreg[7];
        clkHold = (state_d.wireMode == sscs_pkg::WM_TWO_HOLD) & state_d.status;

        // Pin drive: order {clkA, doA, diA, clkB, doB, diB}; OeN low drives
        state_d.pinOut = 6'h00;
        state_d.pinOeN = 6'h3F;
        if (state_d.wireMode == sscs_pkg::WM_THREE)
        begin
            state_d.pinOut = {state_d.clkPort, dout, 1'b0, state_d.clkPort, dout, 1'b0};
            state_d.pinOeN = {~state_d.dir[sscs_pkg::DIR_CLK_POS],
                              ~state_d.dir[sscs_pkg::DIR_DATA_POS], 1'b1,
                              ~state_d.dir[sscs_pkg::DIR_CLK_POS],
                              ~state_d.dir[sscs_pkg::DIR_DATA_POS], 1'b1};
        end
        else if (state_d.wireMode != sscs_pkg::WM_OFF)
        begin
            // Open drain: only ever pulls low
            state_d.pinOeN = {~(state_d.dir[sscs_pkg::DIR_CLK_POS]
                                & (~state_d.clkPort | clkHold)), 1'b1,
                              ~(state_d.dir[sscs_pkg::DIR_DATA_POS] & ~dout),
                              ~(state_d.dir[sscs_pkg::DIR_CLK_POS]
                                & (~state_d.clkPort | clkHold)), 1'b1,
                              ~(state_d.dir[sscs_pkg::DIR_DATA_POS] & ~dout)};
        end
        if (state_d.loc)
            state_d.pinOeN[2:0] = 3'h7;
        else
            state_d.pinOeN[5:3] = 3'h7;
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_q          <= '0;
            state_q.shreg    <= sscs_pkg::RST_DATA;
            state_q.cnt      <= sscs_pkg::RST_COUNT;
            state_q.css      <= sscs_pkg::RST_CSS;
            state_q.wireMode <= sscs_pkg::RST_WM;
            state_q.loc      <= sscs_pkg::RST_LOC;
            state_q.dir      <= sscs_pkg::RST_DIR;
            state_q.mask     <= sscs_pkg::RST_MASK;
            state_q.pinOeN   <= 6'h3F;
        end
        else
            state_q <= state_d;
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign prdata         = state_q.prdata;
    assign pready         = state_q.pready;
    assign pslverr        = state_q.pslverr;
    assign irq            = state_q.irq;
    assign dataInPinBOut  = state_q.pinOut[0];
    assign dataInPinBOeN  = state_q.pinOeN[0];
    assign dataOutPinBOut = state_q.pinOut[1];
    assign dataOutPinBOeN = state_q.pinOeN[1];
    assign clockPinBOut   = state_q.pinOut[2];
    assign clockPinBOeN   = state_q.pinOeN[2];
    assign dataInPinAOut  = state_q.pinOut[3];
    assign dataInPinAOeN  = state_q.pinOeN[3];
    assign dataOutPinAOut = state_q.pinOut[4];
    assign dataOutPinAOeN = state_q.pinOeN[4];
    assign clockPinAOut   = state_q.pinOut[5];
    assign clockPinAOeN   = state_q.pinOeN[5];

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    noClock_a: assert property (
        (cssNow == 2'h0) && !strobe && !cntWr && !dataWr
        |=> $stable(state_q.cnt) && $stable(state_q.shreg))
        else $error("counter or data moved with no clock");
    swStrobe_a: assert property (
        (cssNow == 2'h0) && strobe && !cntWr && !dataWr
        |=> state_q.cnt == 4'($past(state_q.cnt) + 4'h1)
            && state_q.shreg == {$past(state_q.shreg[6:0]), $past(state_q.diPrev)})
        else $error("strobe did not shift and count");
    timerClk_a: assert property (
        (cssNow == 2'h1) && timerMatch && !dataWr
        |=> state_q.shreg[0] == $past(state_q.diPrev))
        else $error("timer match did not shift");
    extBoth_a: assert property (
        cssNow[1] && !selNow && (rise || fall) && !cntWr
        |=> state_q.cnt == 4'($past(state_q.cnt) + 4'h1))
        else $error("external edge did not count");
    extToggle_a: assert property (
        cssNow[1] && selNow && !toggle && !cntWr
        |=> $stable(state_q.cnt))
        else $error("counter moved without toggle strobe");
    oppEdge_a: assert property (
        state_q.css[1] && !ctrlWr && (state_q.css[0] ? rise : fall)
        |=> state_q.doLatch == $past(state_q.shreg[7]))
        else $error("output latch missed opposite edge");
    readZero_a: assert property (
        readCtrl |=> state_q.prdata[1:0] == 2'h0 && state_q.pready)
        else $error("strobe bits read nonzero");
    toggleInv_a: assert property (toggle |=> state_q.clkPort != $past(state_q.clkPort))
        else $error("toggle did not invert clock port");
    pinRoute_a: assert property (
        !state_q.loc ##1 !state_q.loc |-> state_q.pinOeN[5:3] == 3'h7)
        else $error("unselected port driven");
    wrapFlag_a: assert property (
        cntInc && !cntWr && state_q.cnt == 4'hF
        |=> state_q.cnt == 4'h0 && state_q.status ##1 state_q.irq == state_q.mask)
        else $error("overflow wrap or flag wrong");

endmodule

//--- verilog/sscs_pkg.sv
// Package: register map, field layout, reset values and pin routing constants
package sscs_pkg;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_PINPOS = 8'h04;
    localparam logic [7:0] OFF_DATA   = 8'h08;
    localparam logic [7:0] OFF_STATUS = 8'h0C;
    localparam logic [7:0] OFF_MASK   = 8'h10;
    localparam logic [7:0] OFF_COUNT  = 8'h14;
    localparam logic [7:0] OFF_DIR    = 8'h18;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int CTRL_TOGGLE_POS = 0;
    localparam int CTRL_STROBE_POS = 1;
    localparam int CTRL_CSS_POS    = 2;
    localparam int CTRL_WM_POS     = 4;
    localparam int PINPOS_LOC_POS  = 0;
    localparam int STAT_OVF_POS    = 0;
    localparam int DIR_DATA_POS    = 0;
    localparam int DIR_CLK_POS     = 1;

    // ------------------------------------------------------------------
    // Widths, encodings and reset values
    // ------------------------------------------------------------------
    localparam int SYNC_W = 4;
    localparam logic [1:0] CSS_NONE_SW  = 2'h0;
    localparam logic [1:0] CSS_TIMER    = 2'h1;
    localparam logic [1:0] WM_OFF       = 2'h0;
    localparam logic [1:0] WM_THREE     = 2'h1;
    localparam logic [1:0] WM_TWO_HOLD  = 2'h3;
    localparam logic [3:0] CNT_MAX      = 4'hF;
    localparam logic [7:0] RST_DATA     = 8'h00;
    localparam logic [3:0] RST_COUNT    = 4'h0;
    localparam logic [1:0] RST_CSS      = 2'h0;
    localparam logic [1:0] RST_WM       = 2'h0;
    localparam logic       RST_LOC      = 1'b0;
    localparam logic [1:0] RST_DIR      = 2'h0;
    localparam logic       RST_MASK     = 1'b0;

endpackage

//--- verilog/sscs_sync.sv
// Three-stage input synchroniser with agreement filter for the pin inputs
`timescale 1ns/1ps
module sscs_sync
(
    input  wire logic                          clk_sys,
    input  wire logic                          arst_n,
    input  wire logic [sscs_pkg::SYNC_W-1:0]   pinIn,
    output logic      [sscs_pkg::SYNC_W-1:0]   pinOut
);

    typedef struct packed
    {
        logic [sscs_pkg::SYNC_W-1:0] s1;
        logic [sscs_pkg::SYNC_W-1:0] s2;
        logic [sscs_pkg::SYNC_W-1:0] s3;
        logic [sscs_pkg::SYNC_W-1:0] flt;
    } sscs_sync_t;

    sscs_sync_t                  state_q;
    sscs_sync_t                  state_d;
    logic [sscs_pkg::SYNC_W-1:0] agreed;

    // ------------------------------------------------------------------
    // Filter: a change counts only once stages two and three agree
    // ------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < sscs_pkg::SYNC_W; g++)
        begin : gFilt
            assign agreed[g] = (state_q.s2[g] == state_q.s3[g]) ? state_q.s3[g]
                                                               : state_q.flt[g];
        end
    endgenerate

    always_comb
    begin
        state_d     = state_q;
        state_d.s1  = pinIn;
        state_d.s2  = state_q.s1;
        state_d.s3  = state_q.s2;
        state_d.flt = agreed;
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            state_q <= '0;
        else
            state_q <= state_d;
    end

    assign pinOut = state_q.flt;

endmodule
